// ==== rtl/ues_pkg.sv ====
// constants, field layouts and enumerations of the endpoint status block
// assumes one clock domain (aclk) shared by both ends of the link
package ues_pkg;

  // ****************************************
  // register map of the software controller
  // ****************************************
  localparam int unsigned UES_ADDR_W     = 12;
  localparam logic [11:0] UES_CFG_OFS    = 12'h100;
  localparam logic [11:0] UES_STATUS_OFS = 12'h130;
  localparam logic [11:0] UES_CLR_OFS    = 12'h160;
  localparam logic [11:0] UES_SET_OFS    = 12'h190;
  localparam logic [11:0] UES_IRQEN_OFS  = 12'h1C0;
  localparam logic [11:0] UES_CTL_OFS    = 12'h1F0;
  localparam logic [31:0] UES_STATUS_RST = 32'h0000_0100;
  localparam logic [1:0]  UES_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  UES_RESP_SLVERR = 2'h2;

  // ****************************************
  // configuration word layout
  // ****************************************
  localparam int unsigned UES_CFG_W      = 16;
  localparam int unsigned UES_SIZE_LSB   = 4;
  localparam int unsigned UES_DIR_BIT    = 8;
  localparam int unsigned UES_AUTO_BIT   = 9;
  localparam int unsigned UES_TYPE_LSB   = 11;
  localparam logic [10:0] UES_BASE_BYTES = 11'h008;

  // ****************************************
  // status word layout
  // ****************************************
  localparam int unsigned UES_F_TXIN     = 0;
  localparam int unsigned UES_F_RXOUT    = 1;
  localparam int unsigned UES_F_SETUP    = 2;
  localparam int unsigned UES_F_NAKOUT   = 3;
  localparam int unsigned UES_F_NAKIN    = 4;
  localparam int unsigned UES_F_OVER     = 5;
  localparam int unsigned UES_F_STALL    = 6;
  localparam int unsigned UES_TOG_LSB    = 8;
  localparam int unsigned UES_BUSY_LSB   = 12;
  localparam logic [1:0]  UES_TOGGLE_RST = 2'h1;
  localparam logic [1:0]  UES_TOGGLE_SETUP = 2'h0;

  // ****************************************
  // command bits
  // ****************************************
  localparam int unsigned UES_SET_STALL_BIT = 0;
  localparam int unsigned UES_CTL_HAND_BIT  = 0;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    UES_CONTROL = 2'h0,
    UES_ISO     = 2'h1,
    UES_BULK    = 2'h2,
    UES_INTR    = 2'h3
  } ues_xfer_type;

  typedef enum logic [1:0] {
    UES_TOK_OUT   = 2'h0,
    UES_TOK_IN    = 2'h1,
    UES_TOK_SETUP = 2'h2
  } ues_tok_type;

  typedef enum logic [2:0] {
    UES_HS_ACK   = 3'h0,
    UES_HS_NAK   = 3'h1,
    UES_HS_STALL = 3'h2,
    UES_HS_DATA  = 3'h3,
    UES_HS_ZLP   = 3'h4,
    UES_HS_NONE  = 3'h5
  } ues_hs_type;

  typedef enum logic [1:0] {
    UES_SEQ_IDLE = 2'h0,
    UES_SEQ_FLAG = 2'h1,
    UES_SEQ_HAND = 2'h2
  } ues_seq_type;

endpackage

// ==== rtl/ues_ep_if.sv ====
// link between the endpoint logic and its software controller
// assumes both ends run on aclk with the synchronous reset aresetn
interface ues_ep_if (
  input logic aclk,
  input logic aresetn
);
  logic        cfg_wr;
  logic [15:0] cfg_data;
  logic        irqen_wr;
  logic [7:0]  irqen_data;
  logic        clr_wr;
  logic [7:0]  clr_data;
  logic        stall_set;
  logic        hand_clr;
  logic [31:0] status;
  logic [15:0] cfg_rd;
  logic        endpoint_irq;

  modport dev (
    input  aclk, aresetn, cfg_wr, cfg_data, irqen_wr, irqen_data,
    input  clr_wr, clr_data, stall_set, hand_clr,
    output status, cfg_rd, endpoint_irq
  );

  modport ctl (
    input  aclk, aresetn, status, cfg_rd, endpoint_irq,
    output cfg_wr, cfg_data, irqen_wr, irqen_data, clr_wr, clr_data,
    output stall_set, hand_clr
  );
endinterface

// ==== rtl/ues_ep_dev.sv ====
// endpoint configuration, bank bookkeeping and status flags of one endpoint
// assumes tokens come pre-decoded from the packet engine, one per cycle at most
//
// Function
// - bank size is eight bytes shifted by code
// - bus reset clears size except endpoint zero
// - direction 0 OUT, 1 IN; not control
// - auto switch offers next bank once ready
// - transfer type: control, iso, bulk, interrupt
// - control: IN ready when bank free; clear sends
// - other IN: ready flag with handover when free
// - handover clear sends, then next bank offered
// - software clears ready flag before handover bit
// - ready flag stays zero on non-control OUT
// - control: OUT flag on packet, clear frees bank
// - other OUT: flag with handover when bank full
// - software clears OUT flag before handover bit
// - setup flag on control; underflow on iso
// - iso IN with empty bank: underflow, ZLP
// - iso OUT into full bank: dropped, underflow
// - NAK to OUT sets its flag
// - NAK to IN sets its flag
// - oversize OUT acked, truncated, overflow raised
// - stall request set; flag when STALL sent
// - flag and enable raise endpoint interrupt
// - clear register: ones clear, reads zero
// - toggle resets to Data1 seen
//
// Added by the designer: register access over AXI4-Lite.
module ues_ep_dev #(
  parameter int unsigned EP_NUM    = 0,
  parameter int unsigned NUM_BANKS = 2
) (
  // link to controller
  ues_ep_if.dev                  link,
  // usb bus events
  input  logic                   bus_reset,
  // token from packet engine
  input  logic                   tok_valid,
  input  ues_pkg::ues_tok_type   tok_kind,
  input  logic [10:0]            tok_len,
  // answer to packet engine
  output logic                   hs_valid,
  output ues_pkg::ues_hs_type    hs_kind,
  output logic [1:0]             data_pid,
  output logic [10:0]            bank_bytes
);
  import ues_pkg::*;

  if (NUM_BANKS < 1 || NUM_BANKS > 3) begin : g_bank_chk
    $error("ues_ep_dev: NUM_BANKS must be 1 to 3");
  end

  localparam logic [1:0] BANKS = 2'(NUM_BANKS);

  // ****************************************
  // configuration
  // ****************************************
  logic [2:0]   size_q;
  logic         dir_q;
  logic         auto_q;
  ues_xfer_type type_q;
  logic [7:0]   irqen_q;

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      size_q <= 3'h0;
    end else if (bus_reset) begin
      if (EP_NUM != 0) begin
        size_q <= 3'h0;
      end
    end else if (link.cfg_wr) begin
      size_q <= link.cfg_data[UES_SIZE_LSB +: 3];
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn || bus_reset) begin
      dir_q  <= 1'b0;
      auto_q <= 1'b0;
      type_q <= UES_CONTROL;
    end else if (link.cfg_wr) begin
      dir_q  <= link.cfg_data[UES_DIR_BIT];
      auto_q <= link.cfg_data[UES_AUTO_BIT];
      type_q <= ues_xfer_type'(link.cfg_data[UES_TYPE_LSB +: 2]);
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      irqen_q <= 8'h00;
    end else if (link.irqen_wr) begin
      irqen_q <= link.irqen_data;
    end
  end

  logic is_ctrl;
  logic is_iso;
  logic is_in;
  assign is_ctrl    = (type_q == UES_CONTROL);
  assign is_iso     = (type_q == UES_ISO);
  assign is_in      = dir_q && !is_ctrl;
  assign bank_bytes = UES_BASE_BYTES << size_q;

  // ****************************************
  // token handling
  // ****************************************
  logic [1:0]  nbusy_q;
  logic        stall_rq_q;
  logic        hand_q;
  logic [7:0]  flags_q;
  logic        under_q;
  logic [1:0]  toggle_q;
  ues_hs_type  hs_d;
  logic        ev_setup, ev_rxpkt, ev_over, ev_under, ev_nakin, ev_nakout;
  logic        ev_stalled, ev_tog, tok_inc, tok_dec;

  always_comb begin
    hs_d       = UES_HS_NONE;
    ev_setup   = 1'b0;
    ev_rxpkt   = 1'b0;
    ev_over    = 1'b0;
    ev_under   = 1'b0;
    ev_nakin   = 1'b0;
    ev_nakout  = 1'b0;
    ev_stalled = 1'b0;
    ev_tog     = 1'b0;
    tok_inc    = 1'b0;
    tok_dec    = 1'b0;
    if (tok_valid) begin
      case (tok_kind)
        UES_TOK_SETUP: begin
          if (is_ctrl) begin
            hs_d     = UES_HS_ACK;
            ev_setup = 1'b1;
            tok_inc  = (nbusy_q == 2'h0);
          end
        end
        UES_TOK_IN: begin
          if (stall_rq_q) begin
            hs_d       = UES_HS_STALL;
            ev_stalled = 1'b1;
          end else if (nbusy_q != 2'h0) begin
            hs_d    = UES_HS_DATA;
            tok_dec = 1'b1;
            ev_tog  = 1'b1;
          end else if (is_iso) begin
            hs_d     = UES_HS_ZLP;
            ev_under = 1'b1;
          end else begin
            hs_d     = UES_HS_NAK;
            ev_nakin = 1'b1;
          end
        end
        UES_TOK_OUT: begin
          if (stall_rq_q) begin
            hs_d       = UES_HS_STALL;
            ev_stalled = 1'b1;
          end else if (nbusy_q < BANKS) begin
            hs_d     = UES_HS_ACK;
            tok_inc  = 1'b1;
            ev_rxpkt = 1'b1;
            ev_tog   = 1'b1;
            ev_over  = (tok_len > bank_bytes);
          end else if (is_iso) begin
            ev_under = 1'b1;
          end else begin
            hs_d      = UES_HS_NAK;
            ev_nakout = 1'b1;
          end
        end
        default: begin
          hs_d = UES_HS_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      hs_valid <= 1'b0;
      hs_kind  <= UES_HS_NONE;
    end else begin
      hs_valid <= tok_valid && (hs_d != UES_HS_NONE);
      hs_kind  <= hs_d;
    end
  end

  // ****************************************
  // software side of the banks
  // ****************************************
  logic [7:0] clr_vec;
  logic       sw_inc, sw_dec, sw_dec_stp;
  logic       offer_in, offer_out, ctl_in_ready;

  assign clr_vec = link.clr_wr ? link.clr_data : 8'h00;
  // control: clearing the ready flag hands the bank over for sending
  assign sw_inc = (is_ctrl && clr_vec[UES_F_TXIN] && flags_q[UES_F_TXIN])
                || (is_in && link.hand_clr && hand_q);
  // control: clearing OUT or setup flag frees the bank
  assign sw_dec = (is_ctrl && clr_vec[UES_F_RXOUT] && flags_q[UES_F_RXOUT])
                || (!is_ctrl && !dir_q && link.hand_clr && hand_q);
  // setup and OUT banks may both be freed by one clear write
  assign sw_dec_stp = is_ctrl && clr_vec[UES_F_SETUP] && flags_q[UES_F_SETUP];
  // next IN bank offered at once with auto switch, else only when all drained
  assign offer_in  = is_in && !hand_q && (nbusy_q < BANKS)
                   && (auto_q || nbusy_q == 2'h0);
  assign offer_out = !is_ctrl && !dir_q && !hand_q && (nbusy_q != 2'h0);
  assign ctl_in_ready = is_ctrl && (nbusy_q == 2'h0) && !ev_setup
                      && !clr_vec[UES_F_TXIN];

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn || bus_reset) begin
      nbusy_q <= 2'h0;
    end else begin
      nbusy_q <= 2'(3'(nbusy_q) + 3'(tok_inc) + 3'(sw_inc)
                 - 3'(tok_dec) - 3'(sw_dec) - 3'(sw_dec_stp));
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn || bus_reset) begin
      hand_q <= 1'b0;
    end else if (offer_in || offer_out) begin
      hand_q <= 1'b1;
    end else if (link.hand_clr) begin
      hand_q <= 1'b0;
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn || bus_reset) begin
      stall_rq_q <= 1'b0;
    end else if (link.stall_set) begin
      stall_rq_q <= 1'b1;
    end else if (ev_setup) begin
      stall_rq_q <= 1'b0;
    end
  end

  // ****************************************
  // status flags, set wins over clear except the control IN ready flag, where a clear wins
  // ****************************************
  logic [7:0] set_vec;

  always_comb begin
    set_vec              = 8'h00;
    set_vec[UES_F_TXIN]  = offer_in || ctl_in_ready;
    set_vec[UES_F_RXOUT] = (is_ctrl && ev_rxpkt) || offer_out;
    set_vec[UES_F_SETUP] = ev_setup;
    set_vec[UES_F_NAKOUT] = ev_nakout;
    set_vec[UES_F_NAKIN] = ev_nakin;
    set_vec[UES_F_OVER]  = ev_over;
    set_vec[UES_F_STALL] = ev_stalled;
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn || bus_reset) begin
      flags_q <= 8'h00;
      under_q <= 1'b0;
    end else begin
      flags_q <= (flags_q & ~clr_vec) | set_vec;
      under_q <= (under_q & ~clr_vec[UES_F_SETUP]) | ev_under;
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn || bus_reset) begin
      toggle_q <= UES_TOGGLE_RST;
    end else if (ev_setup) begin
      toggle_q <= UES_TOGGLE_SETUP;
    end else if (ev_tog && !is_iso) begin
      toggle_q <= {1'b0, ~toggle_q[0]};
    end
  end

  // ****************************************
  // status word and interrupt
  // ****************************************
  logic [7:0] shown;

  always_comb begin
    shown = flags_q;
    shown[UES_F_TXIN]  = flags_q[UES_F_TXIN] && (is_ctrl || dir_q);
    shown[UES_F_RXOUT] = flags_q[UES_F_RXOUT] && !is_in;
    if (is_iso) begin
      shown[UES_F_SETUP] = under_q;
    end else if (!is_ctrl) begin
      shown[UES_F_SETUP] = 1'b0;
    end
  end

  // status is only ever driven from internal state, never written
  always_comb begin
    link.status = 32'h0000_0000;
    link.status[7:0] = shown;
    link.status[UES_TOG_LSB +: 2]  = toggle_q;
    link.status[UES_BUSY_LSB +: 2] = nbusy_q;
  end

  always_comb begin
    link.cfg_rd = 16'h0000;
    link.cfg_rd[UES_SIZE_LSB +: 3] = size_q;
    link.cfg_rd[UES_DIR_BIT]       = dir_q;
    link.cfg_rd[UES_AUTO_BIT]      = auto_q;
    link.cfg_rd[UES_TYPE_LSB +: 2] = type_q;
  end

  assign link.endpoint_irq = |(shown & irqen_q);
  assign data_pid = toggle_q;

endmodule

// ==== rtl/ues_ep_ctl.sv ====
// software controller: AXI4-Lite slave that drives the endpoint link
// assumes a single AXI4-Lite master on aclk; one write and one read at a time
module ues_ep_ctl (
  // link to endpoint
  ues_ep_if.ctl                    link,
  // axi4-lite write address
  input  logic                     s_awvalid,
  output logic                     s_awready,
  input  logic [ues_pkg::UES_ADDR_W-1:0] s_awaddr,
  // axi4-lite write data
  input  logic                     s_wvalid,
  output logic                     s_wready,
  input  logic [31:0]              s_wdata,
  input  logic [3:0]               s_wstrb,
  // axi4-lite write response
  output logic                     s_bvalid,
  input  logic                     s_bready,
  output logic [1:0]               s_bresp,
  // axi4-lite read
  input  logic                     s_arvalid,
  output logic                     s_arready,
  input  logic [ues_pkg::UES_ADDR_W-1:0] s_araddr,
  output logic                     s_rvalid,
  input  logic                     s_rready,
  output logic [31:0]              s_rdata,
  output logic [1:0]               s_rresp
);
  import ues_pkg::*;

  // ****************************************
  // write channel capture
  // ****************************************
  logic                  aw_have_q, w_have_q;
  logic [UES_ADDR_W-1:0] aw_addr_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;
  ues_seq_type           seq_q;
  logic                  do_write;

  assign s_awready = !aw_have_q && !s_bvalid;
  assign s_wready  = !w_have_q && !s_bvalid;
  assign do_write  = aw_have_q && w_have_q && !s_bvalid && (seq_q == UES_SEQ_IDLE);

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_awvalid && s_awready) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= s_awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      w_have_q <= 1'b1;
      w_data_q <= s_wdata;
      w_strb_q <= s_wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  logic [31:0] wmask;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = w_strb_q[i] ? 8'hFF : 8'h00;
    end
  end

  // ****************************************
  // write decode
  // ****************************************
  logic [31:0] wval;
  logic        hit_w;
  logic [15:0] cfg_val;
  assign wval = w_data_q & wmask;

  always_comb begin
    cfg_val = wval[15:0];
    if (cfg_val[UES_TYPE_LSB +: 2] == UES_CONTROL) begin
      cfg_val[UES_DIR_BIT] = 1'b0;
    end
    if (aw_addr_q == UES_CFG_OFS || aw_addr_q == UES_CLR_OFS
        || aw_addr_q == UES_SET_OFS || aw_addr_q == UES_IRQEN_OFS
        || aw_addr_q == UES_CTL_OFS || aw_addr_q == UES_STATUS_OFS) begin
      hit_w = 1'b1;
    end else begin
      hit_w = 1'b0;
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= UES_RESP_OKAY;
    end else if (do_write) begin
      s_bvalid <= 1'b1;
      s_bresp  <= hit_w ? UES_RESP_OKAY : UES_RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // writes to the status offset fall through and change nothing
  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      link.cfg_wr     <= 1'b0;
      link.cfg_data   <= 16'h0000;
      link.irqen_wr   <= 1'b0;
      link.irqen_data <= 8'h00;
      link.stall_set  <= 1'b0;
    end else begin
      link.cfg_wr    <= do_write && (aw_addr_q == UES_CFG_OFS);
      link.irqen_wr  <= do_write && (aw_addr_q == UES_IRQEN_OFS);
      link.stall_set <= do_write && (aw_addr_q == UES_SET_OFS)
                      && wval[UES_SET_STALL_BIT];
      if (do_write && aw_addr_q == UES_CFG_OFS) begin
        link.cfg_data <= cfg_val;
      end
      if (do_write && aw_addr_q == UES_IRQEN_OFS) begin
        link.irqen_data <= wval[7:0];
      end
    end
  end

  // ****************************************
  // clear path and handover sequence
  // ****************************************
  logic start_hand;
  assign start_hand = do_write && (aw_addr_q == UES_CTL_OFS) && wval[UES_CTL_HAND_BIT];

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      seq_q <= UES_SEQ_IDLE;
    end else begin
      case (seq_q)
        UES_SEQ_IDLE: begin
          if (start_hand) begin
            seq_q <= UES_SEQ_FLAG;
          end
        end
        UES_SEQ_FLAG: begin
          seq_q <= UES_SEQ_HAND;
        end
        default: begin
          seq_q <= UES_SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      link.clr_wr   <= 1'b0;
      link.clr_data <= 8'h00;
      link.hand_clr <= 1'b0;
    end else begin
      link.hand_clr <= (seq_q == UES_SEQ_FLAG);
      if (seq_q == UES_SEQ_IDLE && start_hand) begin
        link.clr_wr   <= 1'b1;
        link.clr_data <= 8'h03;
      end else if (do_write && aw_addr_q == UES_CLR_OFS) begin
        link.clr_wr   <= 1'b1;
        link.clr_data <= wval[7:0];
      end else begin
        link.clr_wr   <= 1'b0;
        link.clr_data <= 8'h00;
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic [31:0] rd_val;
  logic        hit_r;
  logic [7:0]  irqen_shadow_q;

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      irqen_shadow_q <= 8'h00;
    end else if (do_write && aw_addr_q == UES_IRQEN_OFS) begin
      irqen_shadow_q <= wval[7:0];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    hit_r  = 1'b1;
    if (s_araddr == UES_STATUS_OFS) begin
      rd_val = link.status;
    end else if (s_araddr == UES_CFG_OFS) begin
      rd_val = {16'h0000, link.cfg_rd};
    end else if (s_araddr == UES_IRQEN_OFS) begin
      rd_val = {24'h00_0000, irqen_shadow_q};
    end else if (s_araddr == UES_CLR_OFS || s_araddr == UES_SET_OFS
                 || s_araddr == UES_CTL_OFS) begin
      rd_val = 32'h0000_0000;
    end else begin
      hit_r = 1'b0;
    end
  end

  assign s_arready = !s_rvalid;

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= UES_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_val;
      s_rresp  <= hit_r ? UES_RESP_OKAY : UES_RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

endmodule

// ==== testbench/ues_link_sva.sv ====
// checker of the endpoint link, beside controller and endpoint
// assumes aclk only and aresetn synchronous active low
module ues_link_sva (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // controller side
  input logic        cfg_wr,
  input logic [15:0] cfg_data,
  input logic        irqen_wr,
  input logic [7:0]  irqen_data,
  input logic        clr_wr,
  input logic [7:0]  clr_data,
  input logic        hand_clr,
  // endpoint side
  input logic [31:0] status,
  input logic [15:0] cfg_rd,
  input logic        endpoint_irq
);
  import ues_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] en_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) en_q <= 8'h00;
    else if (irqen_wr) en_q <= irqen_data;
  end
  property p_irq; endpoint_irq == |(status[7:0] & en_q); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_tog_rst; $rose(aresetn) |-> status[9:8] == UES_TOGGLE_RST; endproperty
  a_tog_rst: assert property (p_tog_rst) else $error("toggle reset");
  property p_tog_enc; !status[9]; endproperty
  a_tog_enc: assert property (p_tog_enc) else $error("toggle code");
  property p_ctl_dir; cfg_rd[12:11] == UES_CONTROL |-> !cfg_rd[8]; endproperty
  a_ctl_dir: assert property (p_ctl_dir) else $error("control dir");
  property p_out_rdy; (cfg_rd[12:11] != 2'h0 && !cfg_rd[8]) [*2] |-> !status[0]; endproperty
  a_out_rdy: assert property (p_out_rdy) else $error("ready on out");
  property p_bulk_stp; cfg_rd[12] [*2] |-> !status[2]; endproperty
  a_bulk_stp: assert property (p_bulk_stp) else $error("setup on bulk");
  property p_hand; hand_clr |-> $past(clr_wr) && $past(clr_data) == 8'h03; endproperty
  a_hand: assert property (p_hand) else $error("handover order");
  property p_cfg;
    cfg_wr |=> (cfg_rd & 16'h1B70) == ($past(cfg_data) & 16'h1B70);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config load");
endmodule

// ==== testbench/tb_top.sv ====
// bench: controller and endpoint joined by the link, driven by axi and tokens
// assumes the rtl/ package, interface and modules are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ues_pkg::*;
  logic        aclk, aresetn, bus_reset, tok_valid, hs_valid;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, ha, hw, hr, h;
  logic [11:0] s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, rd_q;
  logic [10:0] tok_len, bank_bytes;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, resp_q, data_pid;
  logic [15:0] c;
  ues_tok_type tok_kind;
  ues_hs_type  hs_kind;
  int          failures, comparisons, cycles, seed, n;
  ues_ep_if link (.aclk, .aresetn);
  wire  [31:0] st = link.status;
  ues_ep_dev i_ues_ep_dev (.link, .bus_reset, .tok_valid, .tok_kind, .tok_len, .hs_valid,
    .hs_kind, .data_pid, .bank_bytes);
  ues_ep_ctl i_ues_ep_ctl (.link, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid, .s_wready,
    .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr,
    .s_rvalid, .s_rready, .s_rdata, .s_rresp);
  ues_link_sva i_ues_link_sva (.aclk, .aresetn, .cfg_wr(link.cfg_wr),
    .cfg_data(link.cfg_data), .irqen_wr(link.irqen_wr), .irqen_data(link.irqen_data),
    .clr_wr(link.clr_wr), .clr_data(link.clr_data), .hand_clr(link.hand_clr),
    .status(st), .cfg_rd(link.cfg_rd), .endpoint_irq(link.endpoint_irq));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] cfg_exp(input logic [15:0] v);
    cfg_exp = {16'h0000, v & 16'h1B70};
    if (v[12:11] == 2'h0) cfg_exp[8] = 1'b0;
  endfunction
  // one axi write (wr=1) or read (wr=0), held until answered
  task automatic ax(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awvalid <= wr;
    s_wvalid <= wr;
    s_bready <= wr;
    s_arvalid <= !wr;
    s_rready <= !wr;
    s_awaddr <= a;
    s_araddr <= a;
    s_wdata <= d;
    do begin
      @(negedge aclk);
      {ha, hw, hr} = {s_awready, s_wready, s_arready};
      h = wr ? s_bvalid : s_rvalid;
      rd_q = s_rdata;
      resp_q = wr ? s_bresp : s_rresp;
      @(posedge aclk);
      if (ha) s_awvalid <= 1'b0;
      if (hw) s_wvalid <= 1'b0;
      if (hr) s_arvalid <= 1'b0;
    end while (!h);
    s_bready <= 1'b0;
    s_rready <= 1'b0;
    #1;
  endtask
  task automatic tok(input ues_tok_type k, input int l, input ues_hs_type e);
    @(posedge aclk);
    tok_valid <= 1'b1;
    tok_kind <= k;
    tok_len <= 11'(l);
    @(posedge aclk);
    tok_valid <= 1'b0;
    #1;
    chk(hs_valid, e != UES_HS_NONE);
    if (e != UES_HS_NONE) chk(hs_kind, e);
  endtask
  task automatic brst;
    @(posedge aclk);
    bus_reset <= 1'b1;
    @(posedge aclk);
    bus_reset <= 1'b0;
    #1;
  endtask
  task automatic settle;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end
  // ****
  // sequence
  // ****
  initial begin
    seed = 32'h4D222D15;
    {aresetn, bus_reset, tok_valid, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    {s_awaddr, s_araddr, s_wdata, tok_len} = '0;
    s_wstrb = 4'hF;
    tok_kind = UES_TOK_OUT;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    ax(1'b0, UES_STATUS_OFS, 0);
    chk(rd_q, UES_STATUS_RST | 32'h1);
    ax(1'b1, UES_STATUS_OFS, $random(seed));
    chk(resp_q, UES_RESP_OKAY);
    ax(1'b0, UES_STATUS_OFS, 0);
    chk(rd_q, 32'h0000_0101);
    ax(1'b1, 12'h004, 32'hFFFF_FFFF);
    chk(resp_q, UES_RESP_SLVERR);
    ax(1'b0, UES_CLR_OFS, 0);
    chk(rd_q, 32'h0);
    for (int i = 0; i < 8; i++) begin
      c = 16'($random(seed)) & 16'h0300 | 16'(i % 4) << 11 | 16'(i) << 4;
      ax(1'b1, UES_CFG_OFS, {16'h0, c});
      ax(1'b0, UES_CFG_OFS, 0);
      chk(rd_q, cfg_exp(c));
      chk(bank_bytes, UES_BASE_BYTES << i);
    end
    ax(1'b1, UES_CFG_OFS, 32'h0);
    ax(1'b1, UES_IRQEN_OFS, 32'hFF);
    ax(1'b1, UES_CLR_OFS, 32'hFE);
    tok(UES_TOK_IN, 0, UES_HS_NAK);
    tok(UES_TOK_SETUP, 8, UES_HS_ACK);
    tok(UES_TOK_OUT, 9, UES_HS_ACK);
    chk(st[5:1], 5'h1B);
    tok(UES_TOK_OUT, 4, UES_HS_NAK);
    chk(st[3], 1'b1);
    ax(1'b1, UES_CLR_OFS, 32'h3E);
    chk(st[6:1], 6'h0);
    chk(st[13:12], 2'h0);
    ax(1'b1, UES_SET_OFS, 32'h1);
    tok(UES_TOK_IN, 0, UES_HS_STALL);
    chk(st[6], 1'b1);
    ax(1'b1, UES_CFG_OFS, 32'h1370);
    brst();
    chk(link.cfg_rd, 16'h0070);
    chk(st[13:1], 13'h0080);
    chk(data_pid, UES_TOGGLE_RST);
    ax(1'b1, UES_CFG_OFS, 32'h1100);
    tok(UES_TOK_IN, 0, UES_HS_NAK);
    chk(st[0], 1'b1);
    ax(1'b1, UES_CTL_OFS, 32'h1);
    settle();
    chk({st[13:12], st[0]}, 3'h2);
    tok(UES_TOK_IN, 0, UES_HS_DATA);
    settle();
    chk({st[13:12], st[0]}, 3'h1);
    ax(1'b1, UES_CFG_OFS, 32'h1300);
    ax(1'b1, UES_CTL_OFS, 32'h1);
    settle();
    chk({st[13:12], st[0]}, 3'h3);
    brst();
    ax(1'b1, UES_CFG_OFS, 32'h1000);
    for (int i = 0; i < 3; i++) begin
      n = 1 + {$random(seed)} % 8;
      tok(UES_TOK_OUT, n, i < 2 ? UES_HS_ACK : UES_HS_NAK);
    end
    chk(st[3:0], 4'hA);
    ax(1'b1, UES_CTL_OFS, 32'h1);
    settle();
    chk(st[13:12], 2'h1);
    brst();
    ax(1'b1, UES_CFG_OFS, 32'h0900);
    tok(UES_TOK_IN, 0, UES_HS_ZLP);
    chk(st[2], 1'b1);
    brst();
    ax(1'b1, UES_CFG_OFS, 32'h0800);
    for (int i = 0; i < 3; i++) begin
      tok(UES_TOK_OUT, 8, i < 2 ? UES_HS_ACK : UES_HS_NONE);
    end
    chk(st[2], 1'b1);
    end_sim();
  end
endmodule
